/* rtl/dmd_core.sv */
// Data-move instruction decoder and executor
//
// Operation
// - File-to-file move is two words: 1100 plus source, 1111 plus dest.
// - It copies source byte to destination anywhere in 000h..FFFh, unbanked.
// - Program counter low or stack top bytes as destination are undefined.
// - Two cycles; read in first, no dummy read, Q4 write; flags kept.
// - Accumulator location may be source or destination of that move.
// - 0000 0001 plus literal loads bank select in one cycle.
// - Literal read in Q2, bank select written in Q4, flags kept.
// - 0000 1110 plus literal loads accumulator in Q4, one cycle, flags kept.
// - 0110 111a plus file address stores accumulator to file, flags kept.
// - Bank bit 0 picks access bank; 1 uses bank select register.
`timescale 1ns/10ps
`include "dmd_defs.svh"
module dmd_core
#(
   parameter logic [11:0] ACC_ADDR = 12'hff8
)
(
   // Clock and reset
   input  wire logic                 sys_clk,
   input  wire logic                 rst,
   // Instruction fetch
   input  wire logic                 instr_valid,
   input  wire logic [15:0]          instr_word,
   output logic                      instr_ready,
   // Data memory
   output dmd_pkg::dmd_dm_req_t      dm_req,
   input  wire logic [7:0]           dm_rdata,
   // Core state
   output logic      [7:0]           acc_out,
   output logic      [7:0]           bsr_out,
   output logic                      flag_n,
   output logic                      flag_z,
   output dmd_pkg::dmd_phase_t       phase
);
   import dmd_pkg::*;

   // ======================================================
   // Declarations
   dmd_phase_t  phase_w;
   dmd_state_t  state_q;
   dmd_op_t     op_d;
   dmd_op_t     op_q;
   dmd_dm_req_t dm_q;
   logic [15:0] ir_q;
   logic [7:0]  acc_q;
   logic [7:0]  bsr_q;
   logic [7:0]  data_q;
   logic [7:0]  src_val_w;
   logic [11:0] addr_q;
   logic [11:0] bank_addr_w;
   logic        src_acc_q;
   logic        flag_n_q;
   logic        flag_z_q;
   logic        take_w;

   // ======================================================
   // Sub-blocks
   dmd_qphase u_qphase
   (
      .sys_clk (sys_clk),
      .rst     (rst),
      .phase   (phase_w)
   );
   dmd_bank_addr u_bank_addr
   (
      .file_addr (instr_word[`DMD_LIT_MSB:0]),
      .use_bank  (instr_word[`DMD_A_BIT]),
      .bank_sel  (bsr_q),
      .data_addr (bank_addr_w)
   );

   // ======================================================
   // Fetch handshake, a word is taken in Q1
   assign instr_ready = (phase_w == DMD_Q1);
   assign take_w      = instr_valid && instr_ready;
   // Decode of the offered word
   always_comb
   begin
      op_d = DMD_OP_NONE;
      if (state_q == DMD_ST_SECOND)
      begin
         if (instr_word[`DMD_NIB_MSB:`DMD_NIB_LSB] == `DMD_NIB_FFM2)
            op_d = DMD_OP_FFM2;
      end
      else if (instr_word[`DMD_NIB_MSB:`DMD_NIB_LSB] == `DMD_NIB_FFM1)
         op_d = DMD_OP_FFM1;
      else if (instr_word[`DMD_NIB_MSB:`DMD_BYTE_LSB] == `DMD_BYTE_LBS)
         op_d = DMD_OP_LBS;
      else if (instr_word[`DMD_NIB_MSB:`DMD_BYTE_LSB] == `DMD_BYTE_LACC)
         op_d = DMD_OP_LACC;
      else if (instr_word[`DMD_NIB_MSB:`DMD_ATF_LSB] == `DMD_PAT_ATF)
         op_d = DMD_OP_ATF;
      else if (instr_word[`DMD_NIB_MSB:`DMD_FRM_LSB] == `DMD_PAT_FRM)
         op_d = DMD_OP_FRM;
   end

   // ======================================================
   // Word position, second word follows a move start
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         state_q <= DMD_ST_FIRST;
      else if (take_w)
         case (state_q)
            DMD_ST_FIRST:
               state_q <= (op_d == DMD_OP_FFM1) ? DMD_ST_SECOND
                                                : DMD_ST_FIRST;
            DMD_ST_SECOND:
               state_q <= DMD_ST_FIRST;
            default:
               state_q <= DMD_ST_FIRST;
         endcase
   end
   // Instruction register, bubble when nothing is offered
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         op_q <= DMD_OP_NONE;
         ir_q <= 16'h0000;
      end
      else if (phase_w == DMD_Q1)
      begin
         op_q <= take_w ? op_d : DMD_OP_NONE;
         if (take_w)
            ir_q <= instr_word;
      end
   end
   // Source address and accumulator alias of the read
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         addr_q    <= 12'h000;
         src_acc_q <= 1'b0;
      end
      else if (take_w && op_d == DMD_OP_FFM1)
      begin
         addr_q    <= instr_word[`DMD_ADDR_MSB:0];
         src_acc_q <= (instr_word[`DMD_ADDR_MSB:0] == ACC_ADDR);
      end
      else if (take_w && (op_d == DMD_OP_FRM || op_d == DMD_OP_ATF))
      begin
         addr_q    <= bank_addr_w;
         src_acc_q <= (bank_addr_w == ACC_ADDR);
      end
   end
   // Read value, accumulator alias bypasses memory
   assign src_val_w = src_acc_q ? acc_q : dm_rdata;

   // ======================================================
   // Data memory requests, read in Q2 and write in Q4
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         dm_q <= '0;
      else
      begin
         dm_q.rd <= 1'b0;
         dm_q.wr <= 1'b0;
         if (take_w && op_d == DMD_OP_FFM1)
         begin
            dm_q.addr <= instr_word[`DMD_ADDR_MSB:0];
            dm_q.rd   <= (instr_word[`DMD_ADDR_MSB:0] != ACC_ADDR);
         end
         else if (take_w && (op_d == DMD_OP_FRM || op_d == DMD_OP_ATF))
         begin
            dm_q.addr <= bank_addr_w;
            dm_q.rd   <= (bank_addr_w != ACC_ADDR);
         end
         if (phase_w == DMD_Q3)
            case (op_q)
               DMD_OP_ATF:
               begin
                  dm_q.addr  <= addr_q;
                  dm_q.wdata <= acc_q;
                  dm_q.wr    <= !src_acc_q;
               end
               DMD_OP_FRM:
               begin
                  dm_q.addr  <= addr_q;
                  dm_q.wdata <= src_val_w;
                  dm_q.wr    <= ir_q[`DMD_D_BIT] && !src_acc_q;
               end
               DMD_OP_FFM2:
               begin
                  // Any destination is written, special bytes unguarded
                  dm_q.addr  <= ir_q[`DMD_ADDR_MSB:0];
                  dm_q.wdata <= data_q;
                  dm_q.wr    <= (ir_q[`DMD_ADDR_MSB:0] != ACC_ADDR);
               end
               default:
                  dm_q.wr <= 1'b0;
            endcase
      end
   end
   // Source byte captured in Q3, held across the second word
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         data_q <= 8'h00;
      else if (phase_w == DMD_Q3 &&
               (op_q == DMD_OP_FFM1 || op_q == DMD_OP_FRM))
         data_q <= src_val_w;
   end

   // ======================================================
   // Accumulator written at the end of Q4
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         acc_q <= `DMD_ACC_RST;
      else if (phase_w == DMD_Q4)
         case (op_q)
            DMD_OP_LACC:
               acc_q <= ir_q[`DMD_LIT_MSB:0];
            DMD_OP_FRM:
               if (!ir_q[`DMD_D_BIT])
                  acc_q <= data_q;
            DMD_OP_FFM2:
               if (ir_q[`DMD_ADDR_MSB:0] == ACC_ADDR)
                  acc_q <= data_q;
            default:
               acc_q <= acc_q;
         endcase
   end
   // Bank select written at the end of Q4
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         bsr_q <= `DMD_BSR_RST;
      else if (phase_w == DMD_Q4 && op_q == DMD_OP_LBS)
         bsr_q <= ir_q[`DMD_LIT_MSB:0];
   end
   // Negative and zero flags, only the file move touches them
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         flag_n_q <= `DMD_FLAG_RST;
         flag_z_q <= `DMD_FLAG_RST;
      end
      else if (phase_w == DMD_Q4 && op_q == DMD_OP_FRM)
      begin
         flag_n_q <= data_q[7];
         flag_z_q <= (data_q == 8'h00);
      end
   end

   // ======================================================
   // Outputs
   assign dm_req  = dm_q;
   assign acc_out = acc_q;
   assign bsr_out = bsr_q;
   assign flag_n  = flag_n_q;
   assign flag_z  = flag_z_q;
   assign phase   = phase_w;

   // ======================================================
   // Assertions
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence s_no_mem_4;
      (!dm_q.rd && !dm_q.wr)[*4];
   endsequence
   sequence s_flags_kept_4;
      ($stable(flag_n_q) && $stable(flag_z_q))[*4];
   endsequence
   property p_rd_q2;
      dm_q.rd |-> phase_w == DMD_Q2;
   endproperty
   a_rd_q2: assert property (p_rd_q2)
      else $error("memory read outside Q2");
   property p_wr_q4;
      dm_q.wr |-> phase_w == DMD_Q4;
   endproperty
   a_wr_q4: assert property (p_wr_q4)
      else $error("memory write outside Q4");
   property p_lacc;
      take_w && op_d == DMD_OP_LACC |->
         ##1 s_flags_kept_4 ##0 acc_q == $past(instr_word[7:0], 4);
   endproperty
   a_lacc: assert property (p_lacc)
      else $error("literal not in accumulator after Q4");
   property p_lbs;
      take_w && op_d == DMD_OP_LBS |->
         ##1 s_no_mem_4 ##0 bsr_q == $past(instr_word[7:0], 4);
   endproperty
   a_lbs: assert property (p_lbs)
      else $error("bank select not loaded from literal");
   property p_atf_bank;
      take_w && op_d == DMD_OP_ATF && instr_word[8] &&
         bank_addr_w != ACC_ADDR |->
         ##3 dm_q.wr && dm_q.wdata == acc_q &&
         dm_q.addr == {$past(bsr_q[3:0], 3), $past(instr_word[7:0], 3)};
   endproperty
   a_atf_bank: assert property (p_atf_bank)
      else $error("banked store address or data wrong");
   property p_atf_access;
      take_w && op_d == DMD_OP_ATF && !instr_word[8] |->
         ##1 dm_q.addr == {($past(instr_word[7]) ? `DMD_ACCESS_HI
                                                 : `DMD_ACCESS_LO),
                           $past(instr_word[7:0])};
   endproperty
   a_atf_access: assert property (p_atf_access)
      else $error("access bank store address wrong");
   property p_ffm_read;
      take_w && op_d == DMD_OP_FFM1 && instr_word[11:0] != ACC_ADDR |->
         ##1 dm_q.rd && dm_q.addr == $past(instr_word[11:0]);
   endproperty
   a_ffm_read: assert property (p_ffm_read)
      else $error("move source read missing");
   property p_ffm_second;
      take_w && op_d == DMD_OP_FFM2 && instr_word[11:0] != ACC_ADDR |->
         ##1 !dm_q.rd ##2 dm_q.wr && dm_q.wdata == data_q &&
         dm_q.addr == $past(instr_word[11:0], 3);
   endproperty
   a_ffm_second: assert property (p_ffm_second)
      else $error("move destination write wrong");
   property p_ffm_acc;
      take_w && op_d == DMD_OP_FFM2 && instr_word[11:0] == ACC_ADDR |->
         s_no_mem_4 ##1 acc_q == $past(data_q, 1);
   endproperty
   a_ffm_acc: assert property (p_ffm_acc)
      else $error("move into accumulator wrong");
   property p_frm_acc;
      take_w && op_d == DMD_OP_FRM && !instr_word[9] &&
         bank_addr_w != ACC_ADDR |->
         ##4 acc_q == $past(dm_rdata, 2) && !$past(dm_q.wr);
   endproperty
   a_frm_acc: assert property (p_frm_acc)
      else $error("file move to accumulator wrong");

endmodule

/* rtl/dmd_defs.svh */
// Constants of the data-move instruction decoder
`ifndef DMD_DEFS_SVH
`define DMD_DEFS_SVH

// =========================================================
// Opcode patterns
`define DMD_NIB_FFM1      4'hc
`define DMD_NIB_FFM2      4'hf
`define DMD_BYTE_LBS      8'h01
`define DMD_BYTE_LACC     8'h0e
`define DMD_PAT_ATF       7'h37
`define DMD_PAT_FRM       6'h14

// =========================================================
// Field positions
`define DMD_NIB_MSB       15
`define DMD_NIB_LSB       12
`define DMD_BYTE_LSB      8
`define DMD_ATF_LSB       9
`define DMD_FRM_LSB       10
`define DMD_D_BIT         9
`define DMD_A_BIT         8
`define DMD_LIT_MSB       7
`define DMD_ADDR_MSB      11

// =========================================================
// Reset values
`define DMD_ACC_RST       8'h00
`define DMD_BSR_RST       8'h00
`define DMD_FLAG_RST      1'b0

// =========================================================
// Access bank layout
`define DMD_ACCESS_SPLIT  8'h80
`define DMD_ACCESS_LO     4'h0
`define DMD_ACCESS_HI     4'hf

`endif

/* rtl/dmd_pkg.sv */
// Types shared by the data-move instruction decoder
package dmd_pkg;

   // ======================================================
   // Quarter phases of one instruction cycle
   typedef enum logic [3:0]
   {
      DMD_Q1 = 4'b0001,
      DMD_Q2 = 4'b0010,
      DMD_Q3 = 4'b0100,
      DMD_Q4 = 4'b1000
   } dmd_phase_t;

   // ======================================================
   // Word position inside the instruction stream
   typedef enum logic [1:0]
   {
      DMD_ST_FIRST  = 2'b01,
      DMD_ST_SECOND = 2'b10
   } dmd_state_t;

   // ======================================================
   // Decoded operation
   typedef enum logic [6:0]
   {
      DMD_OP_NONE = 7'b0000001,
      DMD_OP_FFM1 = 7'b0000010,
      DMD_OP_FFM2 = 7'b0000100,
      DMD_OP_LBS  = 7'b0001000,
      DMD_OP_LACC = 7'b0010000,
      DMD_OP_ATF  = 7'b0100000,
      DMD_OP_FRM  = 7'b1000000
   } dmd_op_t;

   // ======================================================
   // Data memory request
   typedef struct packed
   {
      logic        rd;
      logic        wr;
      logic [11:0] addr;
      logic [7:0]  wdata;
   } dmd_dm_req_t;

endpackage

/* rtl/dmd_qphase.sv */
// Quarter phase sequencer of the instruction cycle
`timescale 1ns/10ps
module dmd_qphase
(
   // Clock and reset
   input  wire logic               sys_clk,
   input  wire logic               rst,
   // Current quarter
   output dmd_pkg::dmd_phase_t     phase
);
   import dmd_pkg::*;

   // ======================================================
   // Phase rotation
   dmd_phase_t phase_q;

   // Rotate Q1 to Q4 on every clock
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         phase_q <= DMD_Q1;
      else
         case (phase_q)
            DMD_Q1:  phase_q <= DMD_Q2;
            DMD_Q2:  phase_q <= DMD_Q3;
            DMD_Q3:  phase_q <= DMD_Q4;
            DMD_Q4:  phase_q <= DMD_Q1;
            default: phase_q <= DMD_Q1;
         endcase
   end

   assign phase = phase_q;

endmodule

/* rtl/dmd_bank_addr.sv */
// Forms a 12-bit data address from an 8-bit file field
`timescale 1ns/10ps
`include "dmd_defs.svh"
module dmd_bank_addr
(
   // File field and bank mode
   input  wire logic [7:0]  file_addr,
   input  wire logic        use_bank,
   input  wire logic [7:0]  bank_sel,
   // Full data address
   output logic      [11:0] data_addr
);

   // ======================================================
   // Access bank or bank select mapping
   always_comb
   begin
      if (use_bank)
         data_addr = {bank_sel[3:0], file_addr};
      else if (file_addr < `DMD_ACCESS_SPLIT)
         data_addr = {`DMD_ACCESS_LO, file_addr};
      else
         data_addr = {`DMD_ACCESS_HI, file_addr};
   end

endmodule

/* testbench/dmd_core_bench.sv */
// Self-checking bench of the data-move instruction decoder
`timescale 1ns/10ps
module dmd_core_bench;
   import dmd_pkg::*;

   // =====================================================
   // Signals and data memory
   localparam logic [11:0] ACC_A = 12'hff8;
   logic         sys_clk;
   logic         rst;
   logic         instr_valid;
   logic  [15:0] instr_word;
   logic         instr_ready;
   dmd_dm_req_t  dm_req;
   logic  [7:0]  dm_rdata;
   logic  [7:0]  acc_out;
   logic  [7:0]  bsr_out;
   logic         flag_n;
   logic         flag_z;
   dmd_phase_t   phase;
   logic  [7:0]  mem [0:4095];
   int           miscompares;
   int           n_tests;
   int           rd_cnt;
   int           wr_cnt;
   int           rd0;
   int           wr0;

   dmd_core #(.ACC_ADDR(ACC_A)) dmd_core_inst
   (
      .sys_clk     (sys_clk),
      .rst         (rst),
      .instr_valid (instr_valid),
      .instr_word  (instr_word),
      .instr_ready (instr_ready),
      .dm_req      (dm_req),
      .dm_rdata    (dm_rdata),
      .acc_out     (acc_out),
      .bsr_out     (bsr_out),
      .flag_n      (flag_n),
      .flag_z      (flag_z),
      .phase       (phase)
   );

   // Clock of 8 ns
   initial
   begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   // Synchronous memory; read data is garbage outside the read slot
   always @(posedge sys_clk)
   begin
      dm_rdata <= (dm_req.rd === 1'b1) ? mem[dm_req.addr] : ~dm_rdata;
      if (dm_req.rd === 1'b1)
         rd_cnt <= rd_cnt + 1;
      if (dm_req.wr === 1'b1)
      begin
         mem[dm_req.addr] <= dm_req.wdata;
         wr_cnt <= wr_cnt + 1;
      end
   end

   // Reads only in Q2, writes only in Q4
   always @(negedge sys_clk)
   begin
      if (dm_req.rd === 1'b1)
         chk_bit("rd_in_q2", 1'b1, phase === DMD_Q2);
      if (dm_req.wr === 1'b1)
         chk_bit("wr_in_q4", 1'b1, phase === DMD_Q4);
   end

   // =====================================================
   // Compare, drive and closing tasks
   task automatic chk_val(input string nm, input logic [21:0] e,
                          input logic [21:0] g);
      n_tests++;
      if (g !== e)
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_bit(input string nm, input logic e, input logic g);
      n_tests++;
      if (g !== e)
      begin
         miscompares++;
         $display("BAD %s expected %b seen %b", nm, e, g);
      end
   endtask

   // Offer a word and hold it until the Q1 edge that takes it
   task automatic send(input logic [15:0] w);
      bit got;
      got = 1'b0;
      @(posedge sys_clk);
      instr_valid <= 1'b1;
      instr_word  <= w;
      for (int i = 0; i < 8 && !got; i++)
      begin
         @(negedge sys_clk);
         got = (instr_ready === 1'b1);
         @(posedge sys_clk);
      end
      chk_bit("taken", 1'b1, got);
   endtask

   task automatic idle(input int n);
      instr_valid <= 1'b0;
      repeat (n) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask

   task automatic op(input logic [15:0] w);
      send(w);
      idle(4);
   endtask

   task automatic chk_flags(input logic n, input logic z);
      chk_bit("flag_n", n, flag_n);
      chk_bit("flag_z", z, flag_z);
   endtask

   task automatic end_sim;
      if (miscompares == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // =====================================================
   // Scenarios
   task automatic t_reset;
      @(negedge sys_clk);
      chk_val("phase", 22'(DMD_Q1), 22'(phase));
      chk_val("dm_req", 22'h0, dm_req);
      chk_val("acc", 22'h0, 22'(acc_out));
      chk_val("bsr", 22'h0, 22'(bsr_out));
      chk_flags(1'b0, 1'b0);
   endtask

   task automatic t_frm;
      mem[12'h010] = 8'h80;
      mem[12'h011] = 8'h00;
      op(16'h5011);
      chk_val("acc", 22'h0, 22'(acc_out));
      chk_flags(1'b0, 1'b1);
      wr0 = wr_cnt;
      op(16'h5210);
      chk_val("wr_count", 22'h1, 22'(wr_cnt - wr0));
      chk_val("mem_010", 22'h80, 22'(mem[12'h010]));
      chk_val("acc", 22'h0, 22'(acc_out));
      op(16'h5010);
      chk_val("acc", 22'h80, 22'(acc_out));
      chk_flags(1'b1, 1'b0);
   endtask

   task automatic t_lacc;
      send(16'h0e5a);
      idle(2);
      chk_val("acc_q4", 22'h80, 22'(acc_out));
      @(posedge sys_clk);
      @(negedge sys_clk);
      chk_val("acc", 22'h5a, 22'(acc_out));
      chk_flags(1'b1, 1'b0);
   endtask

   task automatic t_lbs;
      logic [7:0] v [4] = '{8'h05, 8'hff, 8'h00, 8'h05};
      logic [7:0] prev;
      prev = 8'h00;
      for (int i = 0; i < 4; i++)
      begin
         send({8'h01, v[i]});
         idle(2);
         chk_val("bsr_q4", 22'(prev), 22'(bsr_out));
         @(posedge sys_clk);
         @(negedge sys_clk);
         chk_val("bsr", 22'(v[i]), 22'(bsr_out));
         prev = v[i];
      end
      chk_flags(1'b1, 1'b0);
   endtask

   task automatic t_atf;
      logic [15:0] w [4] = '{16'h6f34, 16'h6e12, 16'h6e9a, 16'h6ef8};
      logic [11:0] a [4] = '{12'h534, 12'h012, 12'hf9a, ACC_A};
      for (int i = 0; i < 4; i++)
      begin
         if (i < 3)
            mem[a[i]] = 8'h00;
         wr0 = wr_cnt;
         op(w[i]);
         chk_val("wr_count", 22'(i < 3), 22'(wr_cnt - wr0));
         if (i < 3)
            chk_val("mem_atf", 22'h5a, 22'(mem[a[i]]));
      end
      chk_val("acc", 22'h5a, 22'(acc_out));
      chk_flags(1'b1, 1'b0);
   endtask

   task automatic t_ffm;
      mem[12'h123] = 8'h33;
      mem[12'habc] = 8'h11;
      send(16'hc123);
      idle(4);
      rd0 = rd_cnt;
      wr0 = wr_cnt;
      send(16'hfabc);
      idle(4);
      chk_val("mem_abc", 22'h33, 22'(mem[12'habc]));
      chk_val("rd_count", 22'h0, 22'(rd_cnt - rd0));
      chk_val("wr_count", 22'h1, 22'(wr_cnt - wr0));
      chk_flags(1'b1, 1'b0);
      // Accumulator alias as source, then as destination
      send(16'hcff8);
      send(16'hf200);
      idle(4);
      chk_val("mem_200", 22'h5a, 22'(mem[12'h200]));
      send(16'hc123);
      send(16'hfff8);
      idle(4);
      chk_val("acc", 22'h33, 22'(acc_out));
   endtask

   task automatic t_abort;
      wr0 = wr_cnt;
      send(16'hc123);
      send(16'h0e77);
      idle(4);
      chk_val("wr_count", 22'h0, 22'(wr_cnt - wr0));
      chk_val("acc", 22'h33, 22'(acc_out));
      op(16'h0e11);
      chk_val("acc", 22'h11, 22'(acc_out));
      // Banked file move into the accumulator, bank select is 5
      op(16'h5135);
      chk_val("acc", 22'h6f, 22'(acc_out));
      chk_flags(1'b0, 1'b0);
   endtask

   // =====================================================
   // Main sequence and watchdog
   initial
   begin
      rst = 1'b1;
      instr_valid = 1'b0;
      instr_word = 16'h0000;
      dm_rdata = 8'h00;
      rd_cnt = 0;
      wr_cnt = 0;
      miscompares = 0;
      n_tests = 0;
      for (int i = 0; i < 4096; i++)
         mem[i] = 8'(i) ^ 8'h5a;
      repeat (16) @(posedge sys_clk);
      t_reset;
      @(posedge sys_clk);
      rst <= 1'b0;
      t_frm;
      t_lacc;
      t_lbs;
      t_atf;
      t_ffm;
      t_abort;
      end_sim;
   end

   initial
   begin
      repeat (5000) @(posedge sys_clk);
      miscompares++;
      end_sim;
   end
endmodule
